// file: verilog/frame_status_pkg.sv
// Constants, field layouts and carriers for the interrupt status and frame timer bank.
//
// Operation
// [R1] Status bit 7 follows the live positive data line level without latching.
// [R2] After attach, bit 7 reads 0 for low speed, 1 for full speed.
// [R3] With resume select set, status bit 6 is the sticky resume flag.
// [R4] With resume select clear, bit 6 reads 1 when no device is attached.
// [R5] In host mode, SE0-to-idle or idle-to-SE0 sets status bit 5.
// [R6] Each frame timer expiry sets status bit 4.
// [R7] Bits 1 and 0 are transfer-done flags for set B and set A.
// [R8] Reading the low timer address returns revision in bits 7-4, low bits zero.
// [R9] Writing the low timer address loads reload bits 7 to 0.
// [R10] The frame counter advances on the internal 12 MHz tick only.
// [R11] Software writes e0 to the low reload byte for a 1 ms frame.
// [R12] Software must program both reload registers to set the interval.
// [R13] Reading the high timer address returns the count divided by 64.
// [R14] A 1 ms frame spans 12000 ticks of the 12 MHz clock.
// [R15] Software checks remaining frame count before starting a transfer.
// [R16] Writing 1 to a status bit clears it; 0 leaves it.
// [R17] Enables gate only the interrupt level output, not the flags.
// [R18] The frame counter counts down to zero from the programmed value.
// [R19] Frame timer runs only while control bit 0 is set.
// [R20] At zero the counter reloads the interval and flags one expiry.
package frame_status_pkg;

  localparam logic [7:0] ADDR_CTRL1 = 8'h05;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0d;
  localparam logic [7:0] ADDR_FRAME_LOW = 8'h0e;
  localparam logic [7:0] ADDR_FRAME_HIGH = 8'h0f;

  localparam int BIT_DPLUS = 7;
  localparam int BIT_DETECT = 6;
  localparam int BIT_INSERT = 5;
  localparam int BIT_FRAME = 4;
  localparam int BIT_DONE_B = 1;
  localparam int BIT_DONE_A = 0;
  localparam int CTRL_FRAME_EN = 0;
  localparam int CTRL_RESUME_SEL = 6;

  localparam logic [7:0] FLAG_MASK = 8'h73;
  localparam int COUNT_W = 14;
  localparam int COUNT_SHIFT = 6;
  localparam int HIGH_W = 6;
  localparam logic [13:0] RELOAD_RESET = 14'h2ee0;

  localparam int CORE_CLK_HZ = 50000000;
  localparam int TICK_HZ = 12000000;
  localparam logic [31:0] TICK_INC = 32'(TICK_HZ);
  localparam logic [31:0] TICK_MOD = 32'(CORE_CLK_HZ);

  typedef struct packed {
    logic dplus;
    logic se0;
    logic host_mode;
    logic resume_seen;
    logic done_a;
    logic done_b;
  } line_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

endpackage : frame_status_pkg

// file: verilog/usb_host_irq_status_sof_timer.sv
// Interrupt status flags, enables and frame interval down-counter behind the register port.
`timescale 1ns/100ps
module usb_host_irq_status_sof_timer #(
  parameter logic [3:0] REVISION = 4'h5, // Arbitrary value.
  parameter logic [7:0] FLAGS_RESET = 8'h40
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire frame_status_pkg::reg_access_t bus,
  input wire frame_status_pkg::line_events_t line,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic host_irq_out,
  output logic frame_tick,
  output logic [13:0] frame_count
);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enable;
    logic [7:0] ctrl;
    logic [13:0] reload;
    logic [13:0] count;
    logic [31:0] phase;
    logic prev_se0;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    logic tick;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [7:0] status_view;
  logic [32:0] phase_sum;
  logic tick12;

  //////////////////////////////////////////////////////////////////////////////
  // Live status view.

  always_comb begin
    status_view = st_r.flags & frame_status_pkg::FLAG_MASK;
    status_view[frame_status_pkg::BIT_DPLUS] = line.dplus; // see [R1] see [R2]
    if (!st_r.ctrl[frame_status_pkg::CTRL_RESUME_SEL]) begin
      // Presence is the inverted line state: no pull-up means idle SE0.
      status_view[frame_status_pkg::BIT_DETECT] = line.se0; // see [R4]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fractional divider producing the 12 MHz tick from the core clock.

  always_comb begin
    phase_sum = {1'b0, st_r.phase} + {1'b0, frame_status_pkg::TICK_INC};
    tick12 = phase_sum >= {1'b0, frame_status_pkg::TICK_MOD}; // see [R10] see [R14]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_se0 = line.se0;
    st_nxt.rvalid = 1'b0;
    st_nxt.tick = 1'b0;

    // Clears are applied first so that a same-cycle event still sets its flag.
    if (bus.wr && bus.addr == frame_status_pkg::ADDR_IRQ_FLAGS) begin
      st_nxt.flags = st_r.flags & ~bus.wdata; // see [R16]
    end
    if (bus.wr && bus.addr == frame_status_pkg::ADDR_IRQ_ENABLE) begin
      st_nxt.enable = bus.wdata & frame_status_pkg::FLAG_MASK;
    end
    if (bus.wr && bus.addr == frame_status_pkg::ADDR_CTRL1) begin
      st_nxt.ctrl = bus.wdata;
    end
    if (bus.wr && bus.addr == frame_status_pkg::ADDR_FRAME_LOW) begin
      st_nxt.reload[7:0] = bus.wdata; // see [R9] see [R11]
    end
    if (bus.wr && bus.addr == frame_status_pkg::ADDR_FRAME_HIGH) begin
      st_nxt.reload[13:8] = bus.wdata[frame_status_pkg::HIGH_W-1:0]; // see [R12]
    end

    if (line.host_mode && (line.se0 != st_r.prev_se0)) begin
      st_nxt.flags[frame_status_pkg::BIT_INSERT] = 1'b1; // see [R5]
    end
    if (st_r.ctrl[frame_status_pkg::CTRL_RESUME_SEL] && line.resume_seen) begin
      st_nxt.flags[frame_status_pkg::BIT_DETECT] = 1'b1; // see [R3]
    end
    if (line.done_a) begin
      st_nxt.flags[frame_status_pkg::BIT_DONE_A] = 1'b1; // see [R7]
    end
    if (line.done_b) begin
      st_nxt.flags[frame_status_pkg::BIT_DONE_B] = 1'b1; // see [R7]
    end

    if (st_r.ctrl[frame_status_pkg::CTRL_FRAME_EN]) begin // see [R19]
      st_nxt.phase = tick12 ? 32'(phase_sum - {1'b0, frame_status_pkg::TICK_MOD})
                            : phase_sum[31:0];
      if (tick12) begin
        if (st_r.count == '0) begin
          st_nxt.count = st_r.reload; // see [R20]
          st_nxt.tick = 1'b1;
          st_nxt.flags[frame_status_pkg::BIT_FRAME] = 1'b1; // see [R6]
        end else begin
          st_nxt.count = st_r.count - 14'h0001; // see [R18]
        end
      end
    end else begin
      st_nxt.phase = '0;
      st_nxt.count = st_r.reload;
    end

    if (bus.rd) begin
      st_nxt.rvalid = 1'b1;
      case (bus.addr)
        frame_status_pkg::ADDR_CTRL1: st_nxt.rdata = st_r.ctrl;
        frame_status_pkg::ADDR_IRQ_ENABLE: st_nxt.rdata = st_r.enable;
        frame_status_pkg::ADDR_IRQ_FLAGS: st_nxt.rdata = status_view;
        frame_status_pkg::ADDR_FRAME_LOW: st_nxt.rdata = {REVISION, 4'h0}; // see [R8]
        frame_status_pkg::ADDR_FRAME_HIGH:
          st_nxt.rdata = st_r.count[frame_status_pkg::COUNT_W-1:frame_status_pkg::COUNT_SHIFT];
          // see [R13] see [R15]
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // Level output that holds while any enabled flag remains set.
    st_nxt.irq = |(st_nxt.flags & st_nxt.enable & frame_status_pkg::FLAG_MASK); // see [R17]
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= '0;
      // The line idles in SE0 with nothing attached, so no false insert edge follows reset.
      st_r.prev_se0 <= 1'b1;
      st_r.flags <= FLAGS_RESET;
      st_r.reload <= frame_status_pkg::RELOAD_RESET;
      st_r.count <= frame_status_pkg::RELOAD_RESET;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;
  assign host_irq_out = st_r.irq;
  assign frame_tick = st_r.tick;
  assign frame_count = st_r.count;

endmodule : usb_host_irq_status_sof_timer

// file: test/usb_host_irq_status_sof_timer_assertions.sv
// Checker for the status register port and the frame counter outputs.
`timescale 1ns/100ps
module usb_host_irq_status_sof_timer_checker #(
  parameter logic [3:0] REVISION = 4'h5,
  parameter logic [7:0] FLAGS_RESET = 8'h40
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire frame_status_pkg::reg_access_t bus,
  input wire frame_status_pkg::line_events_t line,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic host_irq_out,
  input wire logic frame_tick,
  input wire logic [13:0] frame_count
);
  logic rq;
  logic run_r;
  assign rq = bus.rd && clk_en;
  // Shadow of the timer enable, since the control register is not visible at the ports.
  always_ff @(posedge core_clk) begin
    if (reset) run_r <= 1'b0;
    else if (clk_en && bus.wr && bus.addr == 8'h05) run_r <= bus.wdata[0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (rq |=> rvalid) else $error("no rvalid");
  a_revision_read: assert property (rq && bus.addr == 8'h0e |=> rdata == {REVISION, 4'h0})
    else $error("bad revision");
  a_count_read: assert property (rq && bus.addr == 8'h0f |=>
    {6'h00, rdata} == $past(frame_count) >> 6) else $error("bad count read");
  a_dplus_live: assert property (rq && bus.addr == 8'h0d |=> rdata[7] == $past(line.dplus))
    else $error("bad line bit");
  a_count_step: assert property (frame_count != $past(frame_count) && $past(frame_count) != 0
    && !$past(bus.wr) && !$past(bus.wr, 2) |-> frame_count == $past(frame_count) - 14'h1)
    else $error("bad count step");
  a_tick_at_zero: assert property (frame_tick |-> $past(frame_count) == 14'h0)
    else $error("tick off zero");
  a_frame_held: assert property (!run_r && !bus.wr && !$past(bus.wr) |=> $stable(frame_count))
    else $error("count moved");
  a_irq_masked: assert property (bus.wr && bus.addr == 8'h06 && bus.wdata == 8'h00
    |=> ##1 !host_irq_out) else $error("irq not masked");
  c_tick: cover property (frame_tick);
  c_irq: cover property ($rose(host_irq_out));
  c_done: cover property (rvalid && rdata[1:0] == 2'h3);
endmodule : usb_host_irq_status_sof_timer_checker
////////////////////////////////////////////////////////////////////////////////
bind usb_host_irq_status_sof_timer usb_host_irq_status_sof_timer_checker #(
  .REVISION(REVISION), .FLAGS_RESET(FLAGS_RESET)) u_checker (.core_clk, .reset, .clk_en, .bus,
  .line, .rdata, .rvalid, .host_irq_out, .frame_tick, .frame_count);

// file: test/host_cpu_model.sv
// Host processor model driving the register port.
`timescale 1ns/100ps
module host_cpu_model (
  input wire logic core_clk,
  input wire logic rvalid,
  input wire logic [7:0] rdata,
  output frame_status_pkg::reg_access_t bus
);
  initial bus = '0;
  // Released address and data are inverted so stale values are never mistaken for live ones.
  task automatic cycle(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 bus = '{wr: !rd, rd: rd, addr: a, wdata: d};
    @(posedge core_clk) #1 bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycle(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cycle(1'b1, a, 8'h00);
    d = rvalid ? rdata : 8'hxx;
  endtask : rd
  task automatic set_interval(input logic [13:0] reload);
    wr(8'h0e, reload[7:0]);
    wr(8'h0f, {2'b00, reload[13:8]});
  endtask : set_interval
endmodule : host_cpu_model

// file: test/usb_host_irq_status_sof_timer_bench.sv
// Self-checking bench for the status flags and frame counter bank.
`timescale 1ns/100ps
module usb_host_irq_status_sof_timer_bench;
  logic core_clk;
  logic reset;
  logic clk_en;
  frame_status_pkg::reg_access_t bus;
  frame_status_pkg::line_events_t line;
  logic [7:0] rdata;
  logic rvalid;
  logic host_irq_out;
  logic frame_tick;
  logic [13:0] frame_count;
  int mismatches = 0;
  int num_checks = 0;
  usb_host_irq_status_sof_timer #(.REVISION(4'ha)) u_usb_host_irq_status_sof_timer (.core_clk,
    .reset, .clk_en, .bus, .line, .rdata, .rvalid, .host_irq_out, .frame_tick, .frame_count);
  host_cpu_model u_host_cpu_model (.core_clk, .rvalid, .rdata, .bus);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host_cpu_model.rd(a, v);
    check({8'h00, v}, {8'h00, e});
  endtask : expect_rd
  task automatic pulse(input logic [5:0] m);
    @(posedge core_clk) #1 line = line | m;
    @(posedge core_clk) #1 line = line & ~m;
  endtask : pulse
  task automatic t_status;
    @(posedge core_clk) #1 line.se0 = 1'b0;
    line.dplus = 1'b1;
    expect_rd(8'h0d, 8'ha0);
    pulse(6'h03);
    expect_rd(8'h0d, 8'ha3);
    u_host_cpu_model.wr(8'h06, 8'h01);
    repeat (2) @(posedge core_clk) #1;
    check(16'(host_irq_out), 16'h1);
    u_host_cpu_model.wr(8'h0d, 8'h01);
    repeat (2) @(posedge core_clk) #1;
    check(16'(host_irq_out), 16'h0);
    expect_rd(8'h0d, 8'ha2);
    u_host_cpu_model.wr(8'h06, 8'h00);
    u_host_cpu_model.wr(8'h05, 8'h40);
    u_host_cpu_model.wr(8'h0d, 8'h40);
    expect_rd(8'h0d, 8'ha2);
    pulse(6'h04);
    expect_rd(8'h0d, 8'he2);
    $display("status done");
  endtask : t_status
  task automatic wait_tick(output int n);
    for (n = 1; n < 2000 && frame_tick !== 1'b1; n++) @(posedge core_clk) #1;
  endtask : wait_tick
  task automatic t_frame;
    int n;
    logic [13:0] held;
    u_host_cpu_model.set_interval(14'h00e0);
    expect_rd(8'h0f, 8'h03);
    u_host_cpu_model.wr(8'h0d, 8'hff);
    u_host_cpu_model.wr(8'h05, 8'h01);
    wait_tick(n);
    @(posedge core_clk) #1;
    wait_tick(n);
    // 225 ticks at 12 MHz land between 937 and 938 core cycles.
    check(16'(n > 936 && n < 939), 16'h1);
    expect_rd(8'h0d, 8'h90);
    // With the clock enable low the running counter must freeze.
    clk_en = 1'b0;
    @(posedge core_clk) #1 held = frame_count;
    repeat (20) @(posedge core_clk) #1;
    check({2'b00, frame_count}, {2'b00, held});
    clk_en = 1'b1;
    $display("frame done");
  endtask : t_frame
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    line = 6'h18;
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    expect_rd(8'h0d, 8'h40);
    expect_rd(8'h0e, 8'ha0);
    expect_rd(8'h0f, 8'hbb);
    expect_rd(8'h20, 8'h00);
    $display("reset done");
    t_status();
    t_frame();
    end_of_test();
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule : usb_host_irq_status_sof_timer_bench
